// *** tb/msc_host.sv ***
// Host model that issues register commands to the statistics bank.
`timescale 1ns/1ns
`default_nettype none

module msc_host (
  input wire logic mclk, // System clock.
  output var msc_pkg::msc_cmd_type cmd, // Command to the bank.
  input wire msc_pkg::msc_rsp_type rsp // Answer from the bank.
);
  initial cmd = '0;

  // Idle command lines carry the inverse of the last values, so a stale bus never looks valid.
  task automatic xfer(input logic w, input logic [3:0] s, input logic [31:0] d,
      output logic [31:0] q, output logic e, output logic ok);
    logic [31:0] v;
    v = (w && s == msc_pkg::SEL_LEGACY) ? (d & 32'h4) : d;
    @(posedge mclk);
    #5;
    cmd = '{valid: 1'b1, write: w, sel: s, wdata: v};
    @(posedge mclk);
    #5;
    cmd = '{valid: 1'b0, write: ~w, sel: ~s, wdata: ~v};
    ok = rsp.valid;
    q = rsp.rdata;
    e = rsp.err;
  endtask
endmodule

`default_nettype wire

// *** tb/msc_stats_assertions.sv ***
// Checker for the statistics bank ports.
`timescale 1ns/1ns
`default_nettype none

module msc_stats_chk #(
  parameter int POLL_CYCLES = msc_pkg::POLL_CYCLES
) (
  input wire logic mclk, // System clock.
  input wire logic nrst, // Reset, active low.
  input wire msc_pkg::msc_cmd_type cmd, // Command.
  input wire msc_pkg::msc_rsp_type rsp, // Answer.
  input wire logic tx_byte, // Byte sent.
  input wire msc_pkg::msc_rx_type rx, // Receive outcome.
  input wire logic ack_timeout, // Acknowledgment timeout.
  input wire logic unicast_sent, // Unicast started.
  input wire logic send_fail, // Send failed.
  input wire logic relay_req, // Relay delay request.
  input wire logic sleep_active, // Sleep period.
  input wire msc_pkg::msc_ctl_type ctl // Derived controls.
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  sequence s_leg_wr;
    cmd.valid && cmd.write && cmd.sel == msc_pkg::SEL_LEGACY && cmd.wdata[31:8] == 24'h0;
  endsequence
  sequence s_no_leg;
    !(cmd.valid && cmd.write && cmd.sel == msc_pkg::SEL_LEGACY);
  endsequence

  property p_rsp;
    1'b1 |=> rsp.valid == $past(cmd.valid);
  endproperty
  property p_ro;
    cmd.valid && cmd.write && cmd.sel inside {4'h1, 4'h5, 4'h6} |=> rsp.valid && rsp.err;
  endproperty
  property p_cbc;
    s_leg_wr ##1 s_no_leg |=> ctl.cipher_cbc == $past(cmd.wdata[2], 2);
  endproperty
  property p_flood;
    ctl.flood_hops <= ctl.path_hops;
  endproperty
  property p_mesh;
    ctl.mesh_ack_req == (ctl.mesh_max_sends > 4'h1);
  endproperty
  property p_link;
    ctl.link_ack_req == (ctl.link_max_resends != 4'h0);
  endproperty
  property p_relay;
    relay_req |=> ctl.relay_valid && ctl.relay_slots <= 3'h5;
  endproperty
  property p_hold;
    ctl.hold_indirect |-> ctl.broadcast_ok;
  endproperty

  a_rsp: assert property (p_rsp) else $error("answer not one cycle after command");
  a_ro: assert property (p_ro) else $error("read-only write not refused");
  a_cbc: assert property (p_cbc) else $error("cipher mode not following option bit");
  a_flood: assert property (p_flood) else $error("flood hops above path hops");
  a_mesh: assert property (p_mesh) else $error("mesh ack request mismatch");
  a_link: assert property (p_link) else $error("link ack request mismatch");
  a_relay: assert property (p_relay) else $error("relay delay missing or too large");
  a_hold: assert property (p_hold) else $error("holding role not routing");
endmodule

bind msc_stats msc_stats_chk #(.POLL_CYCLES(POLL_CYCLES)) msc_stats_chk_i (
  .mclk(mclk), .nrst(nrst), .cmd(cmd), .rsp(rsp), .tx_byte(tx_byte), .rx(rx),
  .ack_timeout(ack_timeout), .unicast_sent(unicast_sent), .send_fail(send_fail),
  .relay_req(relay_req), .sleep_active(sleep_active), .ctl(ctl)
);

`default_nettype wire

// *** tb/msc_stats_test.sv ***
// Self-checking testbench for the statistics bank.
`timescale 1ns/1ns
`default_nettype none

`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_mismatch++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, a, b); end end

module msc_stats_test;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic tx_byte = 1'b0;
  logic ack_timeout = 1'b0;
  logic unicast_sent = 1'b0;
  logic send_fail = 1'b0;
  logic relay_req = 1'b0;
  logic sleep_active = 1'b0;
  msc_pkg::msc_rx_type rx = '0;
  msc_pkg::msc_cmd_type cmd;
  msc_pkg::msc_rsp_type rsp;
  msc_pkg::msc_ctl_type ctl;
  int n_mismatch = 0;
  int n_compared = 0;
  int c;
  logic [15:0] lf = 16'h005F;
  logic [15:0] t;
  logic [31:0] mdl [16] = '{8: 32'h4, 10: 32'h7, 11: 32'h1, 12: 32'h3, 13: 32'hA,
      default: 32'h0};
  logic [31:0] mx [16] = '{0: 32'hFFFFFFFF, 2: 32'hFFFF, 3: 32'hFFFF, 4: 32'hFFFF,
      7: 32'h6, 8: 32'hFF, 9: 32'h20, 10: 32'h20, 11: 32'h7, 12: 32'h5, 13: 32'hF,
      default: 32'h0};
  logic [31:0] mn [16] = '{1: 32'h1, 5: 32'h1, 6: 32'h1, 10: 32'h1, 12: 32'h1,
      14: 32'h1, 15: 32'h1, default: 32'h0};

  msc_stats #(.POLL_CYCLES(16)) msc_stats_i (.mclk(mclk), .nrst(nrst), .cmd(cmd),
      .rsp(rsp), .tx_byte(tx_byte), .rx(rx), .ack_timeout(ack_timeout),
      .unicast_sent(unicast_sent), .send_fail(send_fail), .relay_req(relay_req),
      .sleep_active(sleep_active), .ctl(ctl));
  msc_host host_i (.mclk(mclk), .cmd(cmd), .rsp(rsp));

  initial forever #25 mclk = ~mclk;

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf;
  endfunction

  function automatic void inc(input int s);
    if (mdl[s] < (s == 0 ? 32'h0FFFFFFF : 32'hFFFF)) mdl[s] = mdl[s] + 32'h1;
  endfunction

  task automatic rd(input logic [3:0] s);
    logic [31:0] q;
    logic e, ok;
    host_i.xfer(1'b0, s, 32'h0, q, e, ok);
    `CHK(ok, 1'b1)
    `CHK(e, 1'b0)
    `CHK(q, mdl[s])
  endtask

  task automatic wr(input logic [3:0] s, input logic [31:0] d);
    logic [31:0] q;
    logic e, ok, bad;
    bad = d > mx[s] || d < mn[s] || (s == 4'h7 && d == 32'h5);
    host_i.xfer(1'b1, s, d, q, e, ok);
    `CHK(ok, 1'b1)
    `CHK(e, bad)
    if (!bad) mdl[s] = d;
    repeat (2) @(posedge mclk);
    #5;
    `CHK(ctl.broadcast_ok, mdl[7] inside {0, 1, 4})
    `CHK(ctl.hold_indirect, mdl[7] == 1)
    `CHK(ctl.cipher_cbc, mdl[8][2])
    `CHK(ctl.flood_hops, mdl[9] > mdl[10] ? mdl[10] : mdl[9])
    `CHK(ctl.path_hops, mdl[10])
    `CHK(ctl.mesh_max_sends, mdl[11] + 32'h1)
    `CHK(ctl.mesh_ack_req, mdl[11] != 0)
    `CHK(ctl.link_ack_req, mdl[13] != 0)
    `CHK(ctl.link_max_resends, mdl[13])
  endtask

  // Holds one event input high for n back-to-back cycles.
  task automatic ev(input int k, input int n);
    @(posedge mclk);
    #5;
    case (k)
      0: tx_byte = 1'b1;
      1: ack_timeout = 1'b1;
      2: unicast_sent = 1'b1;
      3: send_fail = 1'b1;
      4: relay_req = 1'b1;
      default: rx.done = 1'b1;
    endcase
    repeat (n) begin
      @(posedge mclk);
      case (k)
        0: inc(0);
        1: inc(4);
        2: if (mdl[13] != 0) inc(6);
        3: inc(5);
        5: if (!rx.crc_ok) inc(2);
          else if (rx.hdr_ok && !rx.is_ack) begin
            inc(3);
            if (rx.is_data) mdl[1] = rx.level < 8'h28 ? 32'h28 :
                rx.level > 8'h6E ? 32'h6E : {24'h0, rx.level};
          end
        default: ;
      endcase
    end
    #5;
    {tx_byte, ack_timeout, unicast_sent, send_fail, relay_req, rx.done} = 6'h0;
  endtask

  task tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (100000) @(posedge mclk);
    n_mismatch++;
    tally_and_finish;
  end

  initial begin
    repeat (16) @(posedge mclk);
    #5;
    nrst = 1'b1;
    for (int s = 0; s < 16; s++) rd(s);
    t = rnd();
    ev(0, 1 + t[2:0]);
    rd(4'h0);
    wr(4'h0, 32'h0FFFFFFD);
    ev(0, 5);
    rd(4'h0);
    wr(4'h0, 32'hFFFFFFF0);
    ev(0, 2);
    rd(4'h0);
    rx = '{done: 1'b0, crc_ok: 1'b1, hdr_ok: 1'b1, is_ack: 1'b0, is_data: 1'b1, level: 8'h60};
    ev(5, 1);
    rd(4'h1);
    for (int i = 0; i < 6; i++) begin
      t = rnd();
      rx.level = t[7:0];
      ev(5, 1);
      rd(4'h1);
    end
    rx.is_ack = 1'b1;
    ev(5, 1);
    rd(4'h3);
    rx.is_ack = 1'b0;
    rx.is_data = 1'b0;
    rx.level = mdl[1] > 32'h4B ? 8'h30 : 8'h60;
    ev(5, 1);
    rd(4'h1);
    rd(4'h3);
    rx.hdr_ok = 1'b0;
    ev(5, 1);
    rd(4'h3);
    sleep_active = 1'b1;
    wr(4'h2, 32'hFFFD);
    rx.crc_ok = 1'b0;
    ev(5, 4);
    sleep_active = 1'b0;
    rd(4'h2);
    wr(4'h2, 32'h10000);
    t = rnd();
    wr(4'h3, {16'h0, t});
    wr(4'h4, 32'hFFFE);
    ev(1, 3);
    rd(4'h4);
    ev(3, 2);
    rd(4'h5);
    wr(4'hD, 32'h0);
    ev(2, 2);
    rd(4'h6);
    wr(4'hD, 32'h3);
    ev(2, 3);
    rd(4'h6);
    wr(4'h1, 32'h9);
    wr(4'h5, 32'h9);
    wr(4'h6, 32'h9);
    wr(4'hF, 32'h9);
    for (int r = 0; r < 8; r++) begin
      wr(4'h7, r);
      c = 0;
      repeat (48) begin
        @(posedge mclk);
        #5;
        c += ctl.poll_req;
      end
      `CHK(c != 0, mdl[7] inside {4, 6})
    end
    wr(4'h8, 32'h0);
    wr(4'h8, 32'h4);
    wr(4'hA, 32'h5);
    wr(4'h9, 32'h20);
    wr(4'h9, 32'h3);
    wr(4'hA, 32'h0);
    wr(4'hA, 32'h21);
    wr(4'h9, 32'h21);
    for (int m = 0; m < 9; m++) wr(4'hB, m);
    for (int n = 0; n < 7; n++) begin
      wr(4'hC, n);
      ev(4, 1);
      `CHK(ctl.relay_valid, 1'b1)
      `CHK(ctl.relay_slots <= mdl[12], 1'b1)
    end
    for (int s = 0; s < 16; s++) rd(s);
    // A second reset in mid-run must bring every value back to its default.
    @(posedge mclk);
    #5;
    nrst = 1'b0;
    repeat (2) @(posedge mclk);
    #5;
    nrst = 1'b1;
    mdl = '{8: 32'h4, 10: 32'h7, 11: 32'h1, 12: 32'h3, 13: 32'hA, default: 32'h0};
    for (int s = 0; s < 16; s++) rd(s);
    wr(4'h7, 32'h0);
    tally_and_finish;
  end
endmodule

`default_nettype wire

// *** verilog/msc_pkg.sv ***
// Package with command codes, limits, defaults and carriers for the MAC statistics bank.
// Notes on behaviour
// - Count every sent byte, retries included.
// - Preamble, headers, overhead and CRC bytes count.
// - Byte tally stops at its maximum.
// - Byte tally loads 32-bit writes, resets zero.
// - Signal level holds last data packet magnitude.
// - Signal level reads zero until first packet.
// - Bad-packet tally counts CRC errors, saturates.
// - Writes load the bad-packet, good-packet and timeout tallies.
// - Sleep periods never clear bad-packet tally.
// - Good frames counted, acknowledgments not, saturating.
// - Acknowledgment timeouts counted, saturating.
// - Acked unicast attempts counted while resends enabled.
// - All tallies volatile, defaults after reset.
// - Role 0 to 6, 5 unused, default 0.
// - Indirect coordinator holds unicasts; poller polls periodically.
// - Routing roles repeat received broadcasts.
// - Option bit 2 selects block-chained cipher.
// - Flood hops 0..32, capped by path hops.
// - Path hops 1..32, default 7.
// - Mesh resends 0..7, default 1, nonzero requests acks.
// - Relay delay 1..5 slots, default 3.
// - Nonzero link resends request acks, bound retransmits.
package msc_pkg;

  localparam logic [3:0] SEL_SENT_BYTE = 4'h0;
  localparam logic [3:0] SEL_SIGNAL = 4'h1;
  localparam logic [3:0] SEL_BAD_PKT = 4'h2;
  localparam logic [3:0] SEL_GOOD_PKT = 4'h3;
  localparam logic [3:0] SEL_ACK_TIMEOUT = 4'h4;
  localparam logic [3:0] SEL_SEND_FAIL = 4'h5;
  localparam logic [3:0] SEL_ACKED_SEND = 4'h6;
  localparam logic [3:0] SEL_ROLE = 4'h7;
  localparam logic [3:0] SEL_LEGACY = 4'h8;
  localparam logic [3:0] SEL_FLOOD_HOP = 4'h9;
  localparam logic [3:0] SEL_PATH_HOP = 4'hA;
  localparam logic [3:0] SEL_MESH_RESEND = 4'hB;
  localparam logic [3:0] SEL_RELAY_DELAY = 4'hC;
  localparam logic [3:0] SEL_LINK_RESEND = 4'hD;

  localparam logic [31:0] BYTE_TALLY_MAX = 32'h0FFFFFFF;
  localparam logic [15:0] EVENT_TALLY_MAX = 16'hFFFF;
  localparam logic [7:0] SIGNAL_MIN = 8'h28;
  localparam logic [7:0] SIGNAL_MAX = 8'h6E;
  localparam logic [2:0] ROLE_UNUSED = 3'h5;
  localparam logic [2:0] ROLE_MAX = 3'h6;
  localparam int LEGACY_CBC_BIT = 2;
  localparam logic [7:0] LEGACY_RESET = 8'h04;
  localparam logic [5:0] HOP_MAX = 6'h20;
  localparam logic [5:0] FLOOD_HOP_RESET = 6'h00;
  localparam logic [5:0] PATH_HOP_RESET = 6'h07;
  localparam logic [2:0] MESH_RESEND_RESET = 3'h1;
  localparam logic [2:0] RELAY_MIN = 3'h1;
  localparam logic [2:0] RELAY_MAX = 3'h5;
  localparam logic [2:0] RELAY_RESET = 3'h3;
  localparam logic [3:0] LINK_RESEND_RESET = 4'hA;
  localparam logic [15:0] LFSR_SEED = 16'hACE1;

  localparam int CLK_HZ = 20000000;
  localparam int POLL_PERIOD_MS = 100;
  localparam int POLL_CYCLES = POLL_PERIOD_MS * (CLK_HZ / 1000);

  typedef enum logic [2:0] {
    MSC_ROLE_ROUTER,
    MSC_ROLE_INDIRECT_COORD,
    MSC_ROLE_NONROUTING,
    MSC_ROLE_NONROUTING_COORD,
    MSC_ROLE_POLLER,
    MSC_ROLE_RESERVED,
    MSC_ROLE_NONROUTING_POLLER
  } msc_role_type;

  typedef struct packed {
    logic valid;
    logic write;
    logic [3:0] sel;
    logic [31:0] wdata;
  } msc_cmd_type;

  typedef struct packed {
    logic valid;
    logic err;
    logic [31:0] rdata;
  } msc_rsp_type;

  typedef struct packed {
    logic done;
    logic crc_ok;
    logic hdr_ok;
    logic is_ack;
    logic is_data;
    logic [7:0] level;
  } msc_rx_type;

  typedef struct packed {
    logic broadcast_ok;
    logic hold_indirect;
    logic poll_req;
    logic cipher_cbc;
    logic [5:0] flood_hops;
    logic [5:0] path_hops;
    logic mesh_ack_req;
    logic [3:0] mesh_max_sends;
    logic link_ack_req;
    logic [3:0] link_max_resends;
    logic relay_valid;
    logic [2:0] relay_slots;
  } msc_ctl_type;

endpackage

// *** verilog/msc_stats.sv ***
// MAC statistics tallies and mesh configuration bank behind the serial command port.
`timescale 1ns/1ns
`default_nettype none

module msc_stats #(
  parameter int POLL_CYCLES = msc_pkg::POLL_CYCLES
) (
  input wire logic mclk, // System clock, 20 MHz.
  input wire logic nrst, // Asynchronous reset, active low.
  input wire msc_pkg::msc_cmd_type cmd, // Command from the serial front end.
  output msc_pkg::msc_rsp_type rsp, // Answer one cycle after a command.
  input wire logic tx_byte, // One pulse per byte put on the air.
  input wire msc_pkg::msc_rx_type rx, // Receive packet outcome.
  input wire logic ack_timeout, // Link acknowledgment wait expired.
  input wire logic unicast_sent, // Link unicast transmission started.
  input wire logic send_fail, // Transmission finally failed.
  input wire logic relay_req, // Request a random relay delay.
  input wire logic sleep_active, // Device is in a sleep period.
  output msc_pkg::msc_ctl_type ctl // Derived controls for the radio.
);

  ////////////////////////////////////////////////////////////////////////////
  // Storage.

  logic [31:0] sent_byte_tally;
  logic [7:0] last_signal_level;
  logic [15:0] bad_packet_tally;
  logic [15:0] good_packet_tally;
  logic [15:0] ack_timeout_tally;
  logic [15:0] send_fail_tally;
  logic [15:0] acked_send_tally;
  msc_pkg::msc_role_type role;
  logic [7:0] legacy_options;
  logic [5:0] flood_hop_limit;
  logic [5:0] path_hop_limit;
  logic [2:0] mesh_resend_limit;
  logic [2:0] relay_delay_slots;
  logic [3:0] link_resend_limit;
  logic [15:0] lfsr;
  logic [31:0] poll_count;
  logic sleep_seen;

  logic wr_ok;
  logic wr_err;
  logic [31:0] rd_value;
  logic rx_good;

  function automatic logic [15:0] sat_inc16(input logic [15:0] value, input logic hit);
    if (hit && value != msc_pkg::EVENT_TALLY_MAX) begin
      sat_inc16 = value + 16'h0001;
    end else begin
      sat_inc16 = value;
    end
  endfunction

  function automatic logic wr_to(input logic [3:0] sel);
    wr_to = wr_ok && cmd.sel == sel;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Command decode and range checks.

  always_comb begin
    wr_err = 1'b0;
    if (cmd.sel == msc_pkg::SEL_SIGNAL) begin
      wr_err = 1'b1;
    end else if (cmd.sel == msc_pkg::SEL_SEND_FAIL) begin
      wr_err = 1'b1;
    end else if (cmd.sel == msc_pkg::SEL_ACKED_SEND) begin
      wr_err = 1'b1;
    end else if (cmd.sel == msc_pkg::SEL_BAD_PKT || cmd.sel == msc_pkg::SEL_GOOD_PKT
                 || cmd.sel == msc_pkg::SEL_ACK_TIMEOUT) begin
      wr_err = cmd.wdata[31:16] != 16'h0000;
    end else if (cmd.sel == msc_pkg::SEL_ROLE) begin
      wr_err = cmd.wdata > 32'(msc_pkg::ROLE_MAX) || cmd.wdata == 32'(msc_pkg::ROLE_UNUSED);
    end else if (cmd.sel == msc_pkg::SEL_LEGACY) begin
      wr_err = cmd.wdata[31:8] != 24'h000000;
    end else if (cmd.sel == msc_pkg::SEL_FLOOD_HOP) begin
      wr_err = cmd.wdata > 32'(msc_pkg::HOP_MAX);
    end else if (cmd.sel == msc_pkg::SEL_PATH_HOP) begin
      wr_err = cmd.wdata == 32'h00000000 || cmd.wdata > 32'(msc_pkg::HOP_MAX);
    end else if (cmd.sel == msc_pkg::SEL_MESH_RESEND) begin
      wr_err = cmd.wdata[31:3] != 29'h00000000;
    end else if (cmd.sel == msc_pkg::SEL_RELAY_DELAY) begin
      wr_err = cmd.wdata < 32'(msc_pkg::RELAY_MIN) || cmd.wdata > 32'(msc_pkg::RELAY_MAX);
    end else if (cmd.sel == msc_pkg::SEL_LINK_RESEND) begin
      wr_err = cmd.wdata[31:4] != 28'h0000000;
    end else if (cmd.sel != msc_pkg::SEL_SENT_BYTE) begin
      wr_err = 1'b1;
    end
  end

  assign wr_ok = cmd.valid && cmd.write && !wr_err;
  assign rx_good = rx.done && rx.crc_ok && rx.hdr_ok;

  // Reads only select a value; nothing is updated by them.
  always_comb begin
    rd_value = 32'h00000000;
    if (cmd.sel == msc_pkg::SEL_SENT_BYTE) begin
      rd_value = sent_byte_tally;
    end else if (cmd.sel == msc_pkg::SEL_SIGNAL) begin
      rd_value = {24'h000000, last_signal_level};
    end else if (cmd.sel == msc_pkg::SEL_BAD_PKT) begin
      rd_value = {16'h0000, bad_packet_tally};
    end else if (cmd.sel == msc_pkg::SEL_GOOD_PKT) begin
      rd_value = {16'h0000, good_packet_tally};
    end else if (cmd.sel == msc_pkg::SEL_ACK_TIMEOUT) begin
      rd_value = {16'h0000, ack_timeout_tally};
    end else if (cmd.sel == msc_pkg::SEL_SEND_FAIL) begin
      rd_value = {16'h0000, send_fail_tally};
    end else if (cmd.sel == msc_pkg::SEL_ACKED_SEND) begin
      rd_value = {16'h0000, acked_send_tally};
    end else if (cmd.sel == msc_pkg::SEL_ROLE) begin
      rd_value = {29'h00000000, role};
    end else if (cmd.sel == msc_pkg::SEL_LEGACY) begin
      rd_value = {24'h000000, legacy_options};
    end else if (cmd.sel == msc_pkg::SEL_FLOOD_HOP) begin
      rd_value = {26'h0000000, flood_hop_limit};
    end else if (cmd.sel == msc_pkg::SEL_PATH_HOP) begin
      rd_value = {26'h0000000, path_hop_limit};
    end else if (cmd.sel == msc_pkg::SEL_MESH_RESEND) begin
      rd_value = {29'h00000000, mesh_resend_limit};
    end else if (cmd.sel == msc_pkg::SEL_RELAY_DELAY) begin
      rd_value = {29'h00000000, relay_delay_slots};
    end else if (cmd.sel == msc_pkg::SEL_LINK_RESEND) begin
      rd_value = {28'h0000000, link_resend_limit};
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rsp <= '0;
    end else begin
      rsp.valid <= cmd.valid;
      rsp.err <= cmd.valid && cmd.write && wr_err;
      rsp.rdata <= (cmd.valid && !cmd.write) ? rd_value : 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Tallies. A load and an event in the same cycle count the event on top.

  // Every byte strobe counts; the radio strobes preamble, headers and CRC too.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sent_byte_tally <= 32'h00000000;
    end else if (wr_to(msc_pkg::SEL_SENT_BYTE)) begin
      if (tx_byte && cmd.wdata < msc_pkg::BYTE_TALLY_MAX) begin
        sent_byte_tally <= cmd.wdata + 32'h00000001;
      end else begin
        sent_byte_tally <= cmd.wdata;
      end
    end else if (tx_byte && sent_byte_tally < msc_pkg::BYTE_TALLY_MAX) begin
      sent_byte_tally <= sent_byte_tally + 32'h00000001;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      last_signal_level <= 8'h00;
    end else if (rx_good && rx.is_data && !rx.is_ack) begin
      if (rx.level < msc_pkg::SIGNAL_MIN) begin
        last_signal_level <= msc_pkg::SIGNAL_MIN;
      end else if (rx.level > msc_pkg::SIGNAL_MAX) begin
        last_signal_level <= msc_pkg::SIGNAL_MAX;
      end else begin
        last_signal_level <= rx.level;
      end
    end
  end

  // Sleep is deliberately absent from this process, so sleeping never clears it.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      bad_packet_tally <= 16'h0000;
    end else if (wr_to(msc_pkg::SEL_BAD_PKT)) begin
      bad_packet_tally <= sat_inc16(cmd.wdata[15:0], rx.done && !rx.crc_ok);
    end else begin
      bad_packet_tally <= sat_inc16(bad_packet_tally, rx.done && !rx.crc_ok);
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      good_packet_tally <= 16'h0000;
    end else if (wr_to(msc_pkg::SEL_GOOD_PKT)) begin
      good_packet_tally <= sat_inc16(cmd.wdata[15:0], rx_good && !rx.is_ack);
    end else begin
      good_packet_tally <= sat_inc16(good_packet_tally, rx_good && !rx.is_ack);
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ack_timeout_tally <= 16'h0000;
    end else if (wr_to(msc_pkg::SEL_ACK_TIMEOUT)) begin
      ack_timeout_tally <= sat_inc16(cmd.wdata[15:0], ack_timeout);
    end else begin
      ack_timeout_tally <= sat_inc16(ack_timeout_tally, ack_timeout);
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      send_fail_tally <= 16'h0000;
    end else begin
      send_fail_tally <= sat_inc16(send_fail_tally, send_fail);
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      acked_send_tally <= 16'h0000;
    end else begin
      acked_send_tally <= sat_inc16(acked_send_tally,
                                    unicast_sent && link_resend_limit != 4'h0);
    end
  end

  // Kept only to show sleep has no path into any tally.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sleep_seen <= 1'b0;
    end else begin
      sleep_seen <= sleep_active;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers.

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      role <= msc_pkg::MSC_ROLE_ROUTER;
      legacy_options <= msc_pkg::LEGACY_RESET;
      flood_hop_limit <= msc_pkg::FLOOD_HOP_RESET;
      path_hop_limit <= msc_pkg::PATH_HOP_RESET;
      mesh_resend_limit <= msc_pkg::MESH_RESEND_RESET;
      relay_delay_slots <= msc_pkg::RELAY_RESET;
      link_resend_limit <= msc_pkg::LINK_RESEND_RESET;
    end else begin
      if (wr_to(msc_pkg::SEL_ROLE)) begin
        role <= msc_pkg::msc_role_type'(cmd.wdata[2:0]);
      end
      if (wr_to(msc_pkg::SEL_LEGACY)) begin
        legacy_options <= cmd.wdata[7:0];
      end
      if (wr_to(msc_pkg::SEL_FLOOD_HOP)) begin
        flood_hop_limit <= cmd.wdata[5:0];
      end
      if (wr_to(msc_pkg::SEL_PATH_HOP)) begin
        path_hop_limit <= cmd.wdata[5:0];
      end
      if (wr_to(msc_pkg::SEL_MESH_RESEND)) begin
        mesh_resend_limit <= cmd.wdata[2:0];
      end
      if (wr_to(msc_pkg::SEL_RELAY_DELAY)) begin
        relay_delay_slots <= cmd.wdata[2:0];
      end
      if (wr_to(msc_pkg::SEL_LINK_RESEND)) begin
        link_resend_limit <= cmd.wdata[3:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Derived controls.

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      lfsr <= msc_pkg::LFSR_SEED;
    end else begin
      lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      poll_count <= 32'h00000000;
    end else if (role != msc_pkg::MSC_ROLE_POLLER
                 && role != msc_pkg::MSC_ROLE_NONROUTING_POLLER) begin
      poll_count <= 32'h00000000;
    end else if (poll_count >= 32'(POLL_CYCLES - 1)) begin
      poll_count <= 32'h00000000;
    end else begin
      poll_count <= poll_count + 32'h00000001;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ctl <= '0;
    end else begin
      ctl.broadcast_ok <= role == msc_pkg::MSC_ROLE_ROUTER
                          || role == msc_pkg::MSC_ROLE_INDIRECT_COORD
                          || role == msc_pkg::MSC_ROLE_POLLER;
      ctl.hold_indirect <= role == msc_pkg::MSC_ROLE_INDIRECT_COORD;
      ctl.poll_req <= (role == msc_pkg::MSC_ROLE_POLLER
                       || role == msc_pkg::MSC_ROLE_NONROUTING_POLLER)
                      && poll_count >= 32'(POLL_CYCLES - 1);
      ctl.cipher_cbc <= legacy_options[msc_pkg::LEGACY_CBC_BIT];
      ctl.flood_hops <= (flood_hop_limit > path_hop_limit) ? path_hop_limit
                                                           : flood_hop_limit;
      ctl.path_hops <= path_hop_limit;
      ctl.mesh_ack_req <= mesh_resend_limit != 3'h0;
      ctl.mesh_max_sends <= {1'b0, mesh_resend_limit} + 4'h1;
      ctl.link_ack_req <= link_resend_limit != 4'h0;
      ctl.link_max_resends <= link_resend_limit;
      ctl.relay_valid <= relay_req;
      if (relay_req) begin
        ctl.relay_slots <= 3'(lfsr[7:0] % ({5'h00, relay_delay_slots} + 8'h01));
      end
    end
  end

endmodule

`default_nettype wire
